// >>> core/osc_consts.svh
// Purpose: constants for the oscillator select control block
// Assumes: apb byte addresses, one 32-bit word per register
// Notes  : all offsets and field positions live here, with the pin select reset value
//
// Function
// - three-bit source code, eight oscillator choices
// - current source field bits 14-12, read-only
// - requested source bits 10-8, strap at power-on
// - bit 5 shows pll locked or timer done
// - only power-on reset restores this register
// - clock fail clear-only; bits 1,0 read-write
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define OSC_ADDR_CTRL      12'h000
`define OSC_ADDR_PINSEL    12'h004

// ----------------------------------------------------------------
// field positions of the control register
// ----------------------------------------------------------------
`define OSC_CUR_LSB        12
`define OSC_REQ_LSB        8
`define OSC_BIT_FREEZE     7
`define OSC_BIT_PINFRZ     6
`define OSC_BIT_LOCK       5
`define OSC_BIT_FAIL       3
`define OSC_BIT_LPEN       1
`define OSC_BIT_SWREQ      0

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define OSC_PINSEL_RST     16'h0000
`define OSC_SETTLE_CYC     4'h4

`endif

// >>> core/osc_pkg.sv
// Purpose: types for the oscillator select control block
// Assumes: nothing beyond the constants header
// Notes  : source code encoding is the three-bit clock select
package osc_pkg;
    // three-bit source encoding
    typedef enum logic [2:0] {
        OSC_FAST_INTERNAL_RC        = 3'h0,
        OSC_FAST_RC_WITH_MULTIPLIER = 3'h1,
        OSC_PRI                     = 3'h2,
        OSC_PRI_PLL                 = 3'h3,
        OSC_SEC                     = 3'h4,
        OSC_LOW_POWER_INTERNAL_RC   = 3'h5,
        OSC_FAST_RC_DIV16           = 3'h6,
        OSC_FAST_RC_DIVN            = 3'h7
    } osc_src_t;

    // switch sequencer states
    typedef enum logic [1:0] {
        OSC_IDLE,
        OSC_SETTLE,
        OSC_DONE
    } osc_sw_state_t;
endpackage

// >>> core/osc_src_decode.sv
// Purpose: one-hot decode of the active source code
// Assumes: code is already registered
// Notes  : drives the clock mux selects and the pll enable
`timescale 1ns/10ps
module osc_src_decode
    import osc_pkg::*;
(
    input  wire logic [2:0] i_code,     // active source code
    output logic      [7:0] o_onehot,   // one select per source
    output logic            o_pll_used  // pll in clock path
);
    // one select line per code value
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_sel
            assign o_onehot[g] = (i_code == 3'(g));
        end
    endgenerate

    // only two codes route through the pll
    assign o_pll_used = (i_code == OSC_PRI_PLL) ||
                        (i_code == OSC_FAST_RC_WITH_MULTIPLIER);
endmodule

// >>> core/osc_select_ctrl.sv
// Purpose: oscillator select control register with apb access
// Assumes: i_reset is power-on only; i_pll_lock synchronous
// Notes  : pin select register models the remap-protected space
`timescale 1ns/10ps
`include "osc_consts.svh"
module osc_select_ctrl
    import osc_pkg::*;
(
    input  wire logic        i_mclk,          // system clock
    input  wire logic        i_reset,         // power-on reset, sync
    input  wire logic [2:0]  i_strap_src,     // nonvolatile source setting
    input  wire logic        i_switch_enable, // config: switching allowed
    input  wire logic        i_fsm_disable,   // config: fail-safe monitor off
    input  wire logic        i_pll_lock,      // pll in lock or timer done
    input  wire logic        i_clock_fail,    // fail-safe detected loss
    input  wire logic        psel,            // apb select
    input  wire logic        penable,         // apb enable
    input  wire logic        pwrite,          // apb direction
    input  wire logic [11:0] paddr,           // apb byte address
    input  wire logic [31:0] pwdata,          // apb write data
    output logic             pready,          // apb ready
    output logic      [31:0] prdata,          // apb read data
    output logic             pslverr,         // apb error
    output logic       [7:0] o_src_sel,       // one-hot clock mux select
    output logic             o_pll_enable,    // pll needed by source
    output logic             o_lp_osc_enable, // low-power osc kept on
    output logic      [15:0] o_pin_select     // protected pin select value
);
    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [2:0]    cur_q;        // current source code
    logic [2:0]    req_q;        // requested source code
    logic          freeze_q;     // switch freeze
    logic          pinfrz_q;     // pin remap freeze
    logic          fail_q;       // clock fail flag
    logic          lpen_q;       // low power osc enable
    logic          swreq_q;      // switch request
    logic          strap_q;      // strap load pending after reset
    logic [15:0]   pinsel_q;     // pin select register
    osc_sw_state_t st_q;         // switch sequencer
    logic [3:0]    settle_q;     // settle counter
    logic          wr_ev;        // apb write strobe
    logic          hit_ctrl;     // address decodes control
    logic          hit_pin;      // address decodes pin select
    logic          sw_allowed;   // switching permitted
    logic [15:0]   ctrl_view;    // read image of control

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    // zero wait state slave; unmapped addresses flag an error
    assign pready   = 1'b1;
    assign wr_ev    = psel && penable && pwrite;
    assign hit_ctrl = (paddr == `OSC_ADDR_CTRL);
    assign hit_pin  = (paddr == `OSC_ADDR_PINSEL);
    assign pslverr  = psel && penable && !hit_ctrl && !hit_pin;

    // freeze applies only when switching on and monitor off
    assign sw_allowed = i_switch_enable &&
                        !(i_fsm_disable && freeze_q);

    // read image, unimplemented bits zero
    always_comb begin
        ctrl_view                                   = 16'h0000;
        ctrl_view[`OSC_CUR_LSB+2:`OSC_CUR_LSB]      = cur_q;
        ctrl_view[`OSC_REQ_LSB+2:`OSC_REQ_LSB]      = req_q;
        ctrl_view[`OSC_BIT_FREEZE]                  = freeze_q;
        ctrl_view[`OSC_BIT_PINFRZ]                  = pinfrz_q;
        ctrl_view[`OSC_BIT_LOCK]                    = i_pll_lock;
        ctrl_view[`OSC_BIT_FAIL]                    = fail_q;
        ctrl_view[`OSC_BIT_LPEN]                    = lpen_q;
        ctrl_view[`OSC_BIT_SWREQ]                   = swreq_q;
    end

    // registered read data for the access phase
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (hit_ctrl) begin
                prdata <= {16'h0000, ctrl_view};
            end else if (hit_pin) begin
                prdata <= {16'h0000, pinsel_q};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // requested source and strap load
    // ----------------------------------------------------------------
    // strap sampled after reset release, never inside reset itself
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            strap_q <= 1'b1;
        end else begin
            strap_q <= 1'b0;
        end
    end

    // requested source: strap at power-on, then software
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            req_q <= 3'h0;
        end else if (strap_q) begin
            req_q <= i_strap_src;
        end else if (wr_ev && hit_ctrl) begin
            req_q <= pwdata[`OSC_REQ_LSB+2:`OSC_REQ_LSB];
        end
    end

    // ----------------------------------------------------------------
    // plain control bits
    // ----------------------------------------------------------------
    // only i_reset (power-on) touches these; other resets are outside
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            freeze_q <= 1'b0;
            pinfrz_q <= 1'b0;
            lpen_q   <= 1'b0;
        end else if (wr_ev && hit_ctrl) begin
            freeze_q <= pwdata[`OSC_BIT_FREEZE];
            pinfrz_q <= pwdata[`OSC_BIT_PINFRZ];
            lpen_q   <= pwdata[`OSC_BIT_LPEN];
        end
    end

    // clock fail: hardware sets, software clears by writing zero
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            fail_q <= 1'b0;
        end else if (i_clock_fail) begin
            fail_q <= 1'b1;  // set wins over clear
        end else if (wr_ev && hit_ctrl && !pwdata[`OSC_BIT_FAIL]) begin
            fail_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // switch request and sequencer
    // ----------------------------------------------------------------
    // software sets, sequencer clears at the end of the switch
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            swreq_q <= 1'b0;
        end else if (wr_ev && hit_ctrl) begin
            swreq_q <= pwdata[`OSC_BIT_SWREQ];
        end else if (st_q == OSC_DONE) begin
            swreq_q <= 1'b0;
        end
    end

    // a short settle models the clock mux handover
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            st_q     <= OSC_IDLE;
            settle_q <= 4'h0;
        end else begin
            case (st_q)
                OSC_IDLE: begin
                    // refused switches simply stay pending
                    if (swreq_q && sw_allowed && !(wr_ev && hit_ctrl)) begin
                        st_q     <= OSC_SETTLE;
                        settle_q <= `OSC_SETTLE_CYC;
                    end
                end
                OSC_SETTLE: begin
                    if (settle_q == 4'h1) begin
                        st_q <= OSC_DONE;
                    end
                    settle_q <= settle_q - 4'h1;
                end
                OSC_DONE: begin
                    st_q <= OSC_IDLE;
                end
                default: begin
                    st_q <= OSC_IDLE;
                end
            endcase
        end
    end

    // current source: strap at power-on, request copied when done
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            cur_q <= 3'h0;
        end else if (strap_q) begin
            cur_q <= i_strap_src;
        end else if (st_q == OSC_DONE) begin
            cur_q <= req_q;
        end
    end
    // software never writes cur_q

    // ----------------------------------------------------------------
    // protected pin select register
    // ----------------------------------------------------------------
    // writes are dropped, not queued, while the remap freeze is set
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            pinsel_q <= `OSC_PINSEL_RST;
        end else if (wr_ev && hit_pin && !pinfrz_q) begin
            pinsel_q <= pwdata[15:0];
        end
    end

    // ----------------------------------------------------------------
    // clock side outputs
    // ----------------------------------------------------------------
    osc_src_decode u_dec (
        .i_code     (cur_q),
        .o_onehot   (o_src_sel),
        .o_pll_used (o_pll_enable)
    );
    assign o_lp_osc_enable = lpen_q;
    assign o_pin_select    = pinsel_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_fail_set;
        @(posedge i_mclk) disable iff (i_reset)
        i_clock_fail |=> fail_q;
    endproperty
    a_fail_set: assert property (p_fail_set) else $error("fail flag not set");

    property p_pin_frozen;
        @(posedge i_mclk) disable iff (i_reset)
        (wr_ev && hit_pin && pinfrz_q) |=> $stable(pinsel_q);
    endproperty
    a_pin_frozen: assert property (p_pin_frozen) else $error("pin select changed");

    property p_freeze_holds;
        @(posedge i_mclk) disable iff (i_reset)
        (st_q == OSC_IDLE && !sw_allowed) |=> st_q == OSC_IDLE;
    endproperty
    a_freeze_holds: assert property (p_freeze_holds) else $error("switch while frozen");

    property p_switch_done;
        @(posedge i_mclk) disable iff (i_reset)
        (st_q == OSC_DONE && !(wr_ev && hit_ctrl)) |=> (cur_q == $past(req_q)) && !swreq_q;
    endproperty
    a_switch_done: assert property (p_switch_done) else $error("switch not done");

    property p_switch_time;
        @(posedge i_mclk) disable iff (i_reset)
        $rose(st_q == OSC_SETTLE) |-> ##4 st_q == OSC_DONE;
    endproperty
    a_switch_time: assert property (p_switch_time) else $error("settle length wrong");

    property p_cur_stable;
        @(posedge i_mclk) disable iff (i_reset)
        (st_q != OSC_DONE && !strap_q) |=> $stable(cur_q);
    endproperty
    a_cur_stable: assert property (p_cur_stable) else $error("current code moved");

    property p_strap;
        @(posedge i_mclk) disable iff (i_reset)
        strap_q |=> req_q == $past(i_strap_src);
    endproperty
    a_strap: assert property (p_strap) else $error("strap not loaded");

    // read data carries the lock level seen at the setup edge
    property p_lock_bit;
        @(posedge i_mclk) disable iff (i_reset)
        (psel && !penable && !pwrite && hit_ctrl) |=> prdata[`OSC_BIT_LOCK] == $past(i_pll_lock);
    endproperty
    a_lock_bit: assert property (p_lock_bit) else $error("lock bit wrong");

    property p_pll_sel;
        @(posedge i_mclk) disable iff (i_reset)
        o_pll_enable == (cur_q == OSC_PRI_PLL ||
                         cur_q == OSC_FAST_RC_WITH_MULTIPLIER);
    endproperty
    a_pll_sel: assert property (p_pll_sel) else $error("pll select wrong");

    // a zero written to the fail bit clears it when no loss is seen
    property p_fail_clear;
        @(posedge i_mclk) disable iff (i_reset)
        (wr_ev && hit_ctrl && !pwdata[`OSC_BIT_FAIL] && !i_clock_fail) |=> !fail_q;
    endproperty
    a_fail_clear: assert property (p_fail_clear) else $error("fail flag not cleared");

    // unfrozen pin select takes the written word
    property p_pin_write;
        @(posedge i_mclk) disable iff (i_reset)
        (wr_ev && hit_pin && !pinfrz_q) |=> pinsel_q == $past(pwdata[15:0]);
    endproperty
    a_pin_write: assert property (p_pin_write) else $error("pin select write lost");

    // requested source follows software once the strap is in
    property p_req_write;
        @(posedge i_mclk) disable iff (i_reset)
        (wr_ev && hit_ctrl && !strap_q) |=> req_q == $past(pwdata[`OSC_REQ_LSB+2:`OSC_REQ_LSB]);
    endproperty
    a_req_write: assert property (p_req_write) else $error("requested code not written");

    c_switch: cover property (@(posedge i_mclk) st_q == OSC_DONE);
    c_frozen: cover property (@(posedge i_mclk) swreq_q && !sw_allowed);
    c_pinblk: cover property (@(posedge i_mclk) wr_ev && hit_pin && pinfrz_q);
    c_swoff:  cover property (@(posedge i_mclk) swreq_q && !i_switch_enable);
endmodule

// >>> sim/osc_pll_model.sv
// Purpose: pll lock source seen by the oscillator control block
// Assumes: the pll locks a fixed count of cycles after it is enabled
// Notes  : lock drops at the next clock edge after the pll is turned off
`timescale 1ns/10ps
module osc_pll_model #(
    parameter int LOCK_CYC = 8 // start-up count, plain default
) (
    input  wire logic i_mclk,       // system clock
    input  wire logic i_reset,      // power-on reset
    input  wire logic i_pll_enable, // pll asked for by source
    output logic      o_pll_lock    // lock or timer done
);
    // ----------------------------------------------------------------
    // start-up timer
    // ----------------------------------------------------------------
    logic [7:0] cnt_q; // cycles since enable
    // runs only while enabled, so lock never shows early
    always_ff @(posedge i_mclk) begin
        if (i_reset || !i_pll_enable) begin
            cnt_q <= 8'h00;
        end else if (cnt_q != LOCK_CYC[7:0]) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    assign o_pll_lock = (cnt_q == LOCK_CYC[7:0]);
endmodule

// >>> sim/osc_select_ctrl_tb.sv
// Purpose: self-checking bench for the oscillator select control
// Assumes: apb slave ties pready high, zero wait states; the master still waits on pready
// Notes  : random strap and pin values from a fixed seed
`timescale 1ns/10ps
`include "osc_consts.svh"
module tb;
    import osc_pkg::*;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic        i_mclk, i_reset, sw_en, fsm_dis, clk_fail;   // clock, reset, config
    logic        psel, penable, pwrite, pready, pslverr, err; // apb control
    logic        pll_en, lp_en, pll_lock;                     // clock side
    logic [2:0]  strap;                                       // nonvolatile code
    logic [11:0] paddr;                                       // apb address
    logic [31:0] pwdata, prdata, rd;                          // apb data
    logic [7:0]  src_sel;                                     // one-hot select
    logic [15:0] pin_sel, pval;                               // pin select
    int          fail_count, compares;                        // tallies

    osc_select_ctrl dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_strap_src(strap),
        .i_switch_enable(sw_en), .i_fsm_disable(fsm_dis), .i_pll_lock(pll_lock),
        .i_clock_fail(clk_fail), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .o_src_sel(src_sel), .o_pll_enable(pll_en),
        .o_lp_osc_enable(lp_en), .o_pin_select(pin_sel));
    osc_pll_model pll (.i_mclk(i_mclk), .i_reset(i_reset), .i_pll_enable(pll_en),
        .o_pll_lock(pll_lock));

    // free-running 100 mhz clock
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] ctrl(input logic [2:0] c, input logic [2:0] q,
                                         input logic [7:0] low);
        return {16'h0000, 1'b0, c, 1'b0, q, low};
    endfunction
    function automatic logic pll_of(input logic [2:0] c);
        return (c == 3'h3) || (c == 3'h1);
    endfunction
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask
    // one transfer; idles a cycle after so strobes never toggle twice at one edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge i_mclk);
        penable <= 1'b1;
        @(posedge i_mclk);
        while (pready !== 1'b1) @(posedge i_mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic do_reset();
        i_reset <= 1'b1;
        repeat (8) @(posedge i_mclk);
        i_reset <= 1'b0;
        repeat (2) @(posedge i_mclk);
    endtask
    // request a source, poll until the request bit clears
    task automatic sw_to(input logic [15:0] w);
        apb(1'b1, `OSC_ADDR_CTRL, {16'h0000, w});
        for (int i = 0; i < 20; i++) begin
            apb(1'b0, `OSC_ADDR_CTRL, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        repeat (12) @(posedge i_mclk);
        apb(1'b0, `OSC_ADDR_CTRL, 32'h0);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge i_mclk);
        fail_count++;
        stop_test();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        sw_en = 1'b1; fsm_dis = 1'b0; clk_fail = 1'b0;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        fail_count = 0; compares = 0;
        void'($urandom(32'h4c463430));
        strap = 3'($urandom);
        do_reset();
        // reset values, lock bit masked since the pll may still be starting
        apb(1'b0, `OSC_ADDR_CTRL, 32'h0);
        chk("ctrl_rst", rd & 32'hffdf, ctrl(strap, strap, 8'h00));
        chk("sel_rst", 32'(src_sel), 32'(8'h01 << strap));
        // writes to current code and lock status are ignored
        apb(1'b1, `OSC_ADDR_CTRL, 32'h7020 | 32'(strap) << 8);
        apb(1'b0, `OSC_ADDR_CTRL, 32'h0);
        chk("cur_ro", 32'(rd[14:12]), 32'(strap));
        $display("test reset done");
        // every source code in ascending order, never pll to pll directly
        for (int c = 0; c < 8; c++) begin
            sw_to(16'(c) << 8 | 16'h0001);
            chk("ctrl_sw", rd, ctrl(3'(c), 3'(c), {2'b00, pll_of(3'(c)), 5'h00}));
            chk("sel_sw", 32'(src_sel), 32'(8'h01 << c));
            chk("pll_en", 32'(pll_en), 32'(pll_of(3'(c))));
        end
        $display("test switch done");
        // freeze with monitor off refuses, request stays pending
        fsm_dis <= 1'b1;
        sw_to(16'h0081);
        chk("frz_on", rd, ctrl(3'h7, 3'h0, 8'h81));
        sw_to(16'h0001);
        chk("frz_off", rd, ctrl(3'h0, 3'h0, 8'h00));
        // freeze has no force while the monitor is enabled
        fsm_dis <= 1'b0;
        sw_to(16'h0181);
        chk("frz_mon", rd, ctrl(3'h1, 3'h1, 8'ha0));
        // switching disabled refuses too; the request resumes once enabled
        sw_en <= 1'b0;
        sw_to(16'h0001);
        chk("swen_off", rd, ctrl(3'h1, 3'h0, 8'h21));
        sw_en <= 1'b1;
        sw_to(16'h0001);
        chk("swen_on", rd, ctrl(3'h0, 3'h0, 8'h00));
        $display("test freeze done");
        // pin select writable until its freeze bit is set
        pval = 16'($urandom);
        apb(1'b1, `OSC_ADDR_PINSEL, {16'h0000, pval});
        apb(1'b0, `OSC_ADDR_PINSEL, 32'h0);
        chk("pin_wr", rd, {16'h0000, pval});
        apb(1'b1, `OSC_ADDR_CTRL, 32'h0140);
        apb(1'b1, `OSC_ADDR_PINSEL, {16'h0000, ~pval});
        apb(1'b0, `OSC_ADDR_PINSEL, 32'h0);
        chk("pin_frz", rd, {16'h0000, pval});
        chk("pin_out", 32'(pin_sel), 32'(pval));
        $display("test pin done");
        // fail flag sticky, clear only by writing zero; low-power enable read-write
        clk_fail <= 1'b1;
        @(posedge i_mclk);
        clk_fail <= 1'b0;
        apb(1'b1, `OSC_ADDR_CTRL, 32'h010a);
        apb(1'b0, `OSC_ADDR_CTRL, 32'h0);
        chk("fail_set", 32'(rd[3:0]), 32'ha);
        chk("lp_out", 32'(lp_en), 32'h1);
        apb(1'b1, `OSC_ADDR_CTRL, 32'h0100);
        apb(1'b0, `OSC_ADDR_CTRL, 32'h0);
        chk("fail_clr", 32'(rd[3:0]), 32'h0);
        $display("test fail done");
        // unmapped place answers with an error and reads zero
        apb(1'b1, 12'h008, 32'hffff);
        chk("err_wr", 32'(err), 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk("err_rd", {rd[31:1], err}, 32'h1);
        $display("test unmapped done");
        // a second power-on reset reloads the strap and clears pin select
        strap <= 3'($urandom);
        do_reset();
        apb(1'b0, `OSC_ADDR_CTRL, 32'h0);
        chk("ctrl_por", rd & 32'hffdf, ctrl(strap, strap, 8'h00));
        chk("pin_por", 32'(pin_sel), 32'h0);
        $display("test por done");
        stop_test();
    end
endmodule
